// file: pssc_core.sv
// Notes on behaviour
// - load write when held low, selected, write
// - advance increments counter, internal address used
// - direction input ignored on advance cycles
// - burst direction fixed at its load cycle
// - deselect when unselected and load sampled
// - bus floats two cycles after deselect
// - hold high freezes the pipeline, burst counter and data pins; the apb side keeps running
// - selected needs both lows low, high high
// - any inactive select deselects the chip
// - data outputs float from first edge
// - strobe n governs byte n plus parity
// - several strobes may write together
// - narrow mode writes only two lanes
// - boundary scan stays disabled from power-up
// - burst order high gives interleaved sequence
// - burst order low gives linear sequence
// - counter wraps after fourth address
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pssc_defines.svh"

module pssc_core (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PSSC_PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory command pins
  input wire logic clock_hold_n,
  input wire logic advance_or_load,
  input wire logic read_write,
  input wire logic select_low_a,
  input wire logic select_low_b,
  input wire logic select_high,
  input wire pssc_pkg::pssc_lanes_t byte_lane_write_n,
  input wire logic burst_order_select,
  input wire logic [`PSSC_ADDR_W-1:0] addr,
  // data pins
  input wire logic [`PSSC_DATA_W-1:0] dq_in,
  input wire logic [`PSSC_PAR_W-1:0] dqp_in,
  output logic [`PSSC_DATA_W-1:0] dq_out,
  output logic [`PSSC_PAR_W-1:0] dqp_out,
  output logic dq_oe
);
  import pssc_pkg::*;

  // chip select decode, used only by the command decode
  function automatic logic chip_selected(input logic low_a, input logic low_b, input logic high);
    chip_selected = !low_a && !low_b && high;
  endfunction

  // lanes that really get written: strobe low and lane present
  function automatic logic [`PSSC_LANES-1:0] lane_enables(input pssc_lanes_t strobes_n, input logic narrow);
    logic [`PSSC_LANES-1:0] en;
    en = ~strobes_n;
    if (narrow) begin
      en[3:2] = 2'h0;
    end
    lane_enables = en;
  endfunction

  // storage array, one word per address
  logic [`PSSC_WORD_W-1:0] mem [0:`PSSC_DEPTH-1];

  // pipeline stage one: command taken at edge n
  pssc_kind_t s1_kind_reg;
  pssc_kind_t s1_kind_next;
  logic [`PSSC_ADDR_W-1:0] s1_addr_reg;
  logic [`PSSC_ADDR_W-1:0] s1_addr_next;
  pssc_lanes_t s1_bw_reg;
  pssc_lanes_t s1_bw_next;
  // pipeline stage two: command at edge n+1
  pssc_kind_t s2_kind_reg;
  pssc_kind_t s2_kind_next;
  logic [`PSSC_ADDR_W-1:0] s2_addr_reg;
  logic [`PSSC_ADDR_W-1:0] s2_addr_next;
  pssc_lanes_t s2_bw_reg;
  pssc_lanes_t s2_bw_next;
  // open burst
  pssc_kind_t burst_kind_reg;
  pssc_kind_t burst_kind_next;
  logic [`PSSC_ADDR_W-1:0] burst_addr_reg;
  logic [`PSSC_ADDR_W-1:0] burst_addr_next;
  // data pins
  logic [`PSSC_DATA_W-1:0] dq_out_reg;
  logic [`PSSC_DATA_W-1:0] dq_out_next;
  logic [`PSSC_PAR_W-1:0] dqp_out_reg;
  logic [`PSSC_PAR_W-1:0] dqp_out_next;
  logic dq_oe_reg;
  logic dq_oe_next;
  // apb side
  logic narrow_reg;
  logic narrow_next;
  logic [31:0] rd_cnt_reg;
  logic [31:0] rd_cnt_next;
  logic [31:0] wr_cnt_reg;
  logic [31:0] wr_cnt_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  // decode and helper wires
  logic hold;
  logic selected;
  logic is_load;
  logic is_adv;
  logic [`PSSC_SEQ_W-1:0] seq_lo;
  logic [`PSSC_SEQ_W-1:0] seq_count;
  logic [`PSSC_LANES-1:0] wr_en;
  logic [`PSSC_WORD_W-1:0] mem_rd;
  logic [`PSSC_WORD_W-1:0] wr_word;
  logic [`PSSC_WORD_W-1:0] in_word;
  logic apb_ack;
  logic apb_wr;
  logic clr_cnt;
  logic addr_ok;

  // command decode; hold high blocks the whole memory-side edge, while the apb side still runs
  always_comb begin
    hold = clock_hold_n;
    selected = chip_selected(select_low_a, select_low_b, select_high);
    is_load = !advance_or_load && selected;
    is_adv = advance_or_load;
  end

  // burst sequencer; the low two address bits come from here on advance
  pssc_burst_ctr u_burst_ctr (
    .pclk(pclk),
    .presetn(presetn),
    .hold(hold),
    .load(is_load),
    .advance(is_adv && burst_kind_reg != PSSC_NONE),
    .interleaved(burst_order_select),
    .start_lo(addr[`PSSC_SEQ_W-1:0]),
    .addr_lo(seq_lo),
    .count(seq_count)
  );

  // stage one and burst state
  always_comb begin
    s1_kind_next = s1_kind_reg;
    s1_addr_next = s1_addr_reg;
    s1_bw_next = s1_bw_reg;
    burst_kind_next = burst_kind_reg;
    burst_addr_next = burst_addr_reg;
    if (!hold) begin
      s1_bw_next = byte_lane_write_n;
      if (is_load) begin
        // direction is sampled only here and fixes the whole burst
        s1_kind_next = read_write ? PSSC_READ : PSSC_WRITE;
        s1_addr_next = addr;
        burst_kind_next = s1_kind_next;
        burst_addr_next = addr;
      end else if (is_adv) begin
        // read_write is not looked at on an advance
        s1_kind_next = burst_kind_reg;
        s1_addr_next = {burst_addr_reg[`PSSC_ADDR_W-1:`PSSC_SEQ_W], seq_lo};
      end else begin
        s1_kind_next = PSSC_NONE;
        burst_kind_next = PSSC_NONE;
      end
    end
  end

  // stage two only moves on edges that are not held
  always_comb begin
    s2_kind_next = s2_kind_reg;
    s2_addr_next = s2_addr_reg;
    s2_bw_next = s2_bw_reg;
    if (!hold) begin
      s2_kind_next = s1_kind_reg;
      s2_addr_next = s1_addr_reg;
      s2_bw_next = s1_bw_reg;
    end
  end

  // data stage: write data arrives now, read data is driven after this edge
  always_comb begin
    mem_rd = mem[s2_addr_reg];
    in_word = {dqp_in, dq_in};
    wr_en = 4'h0;
    if (s2_kind_reg == PSSC_WRITE) begin
      wr_en = lane_enables(s2_bw_reg, narrow_reg);
    end
  end

  // lane merge: each strobe picks its byte and its parity bit
  genvar gl;
  generate
    for (gl = 0; gl < `PSSC_LANES; gl = gl + 1) begin : g_lane
      assign wr_word[gl*`PSSC_LANE_W +: `PSSC_LANE_W] =
        wr_en[gl] ? in_word[gl*`PSSC_LANE_W +: `PSSC_LANE_W] : mem_rd[gl*`PSSC_LANE_W +: `PSSC_LANE_W];
      assign wr_word[`PSSC_DATA_W+gl] = wr_en[gl] ? in_word[`PSSC_DATA_W+gl] : mem_rd[`PSSC_DATA_W+gl];
    end
  endgenerate

  // output drivers; a held edge keeps the pins, otherwise the bus floats unless a read completes at this edge
  always_comb begin
    dq_out_next = dq_out_reg;
    dqp_out_next = dqp_out_reg;
    dq_oe_next = dq_oe_reg;
    if (!hold) begin
      if (s2_kind_reg == PSSC_READ) begin
        dq_out_next = mem_rd[`PSSC_DATA_W-1:0];
        dqp_out_next = mem_rd[`PSSC_WORD_W-1:`PSSC_DATA_W];
        if (narrow_reg) begin
          // absent lanes read as zero so a narrow host sees clean upper pins
          dq_out_next[31:16] = 16'h0000;
          dqp_out_next[3:2] = 2'h0;
        end
        dq_oe_next = 1'b1;
      end else begin
        dq_oe_next = 1'b0;
      end
    end
  end

  // array write; a held edge writes nothing
  always_ff @(posedge pclk) begin
    if (!hold && wr_en != 4'h0) begin
      mem[s2_addr_reg] <= wr_word;
    end
  end

  // apb handshake: one wait cycle, data ready with pready
  always_comb begin
    apb_ack = psel && penable && !pready_reg;
    apb_wr = psel && penable && pready_reg && pwrite;
    addr_ok = (paddr == `PSSC_OFF_CTRL) || (paddr == `PSSC_OFF_STATUS) ||
              (paddr == `PSSC_OFF_RDCNT) || (paddr == `PSSC_OFF_WRCNT);
    pready_next = apb_ack;
    pslverr_next = apb_ack && !addr_ok;
    prdata_next = 32'h0000_0000;
    if (apb_ack && !pwrite) begin
      unique case (paddr)
        `PSSC_OFF_CTRL: prdata_next[`PSSC_CTRL_NARROW] = narrow_reg;
        `PSSC_OFF_STATUS: begin
          prdata_next[`PSSC_ST_OE] = dq_oe_reg;
          prdata_next[`PSSC_ST_KIND +: 2] = burst_kind_reg;
          prdata_next[`PSSC_ST_SEQ +: 2] = seq_count;
          prdata_next[`PSSC_ST_SCAN] = 1'b0;
          prdata_next[`PSSC_ST_SUSP] = hold;
        end
        `PSSC_OFF_RDCNT: prdata_next = rd_cnt_reg;
        `PSSC_OFF_WRCNT: prdata_next = wr_cnt_reg;
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // control register and access counters
  always_comb begin
    narrow_next = narrow_reg;
    clr_cnt = 1'b0;
    if (apb_wr && paddr == `PSSC_OFF_CTRL) begin
      narrow_next = pwdata[`PSSC_CTRL_NARROW];
      clr_cnt = pwdata[`PSSC_CTRL_CLR];
    end
    rd_cnt_next = rd_cnt_reg;
    wr_cnt_next = wr_cnt_reg;
    if (!hold && s2_kind_reg == PSSC_READ) begin
      rd_cnt_next = rd_cnt_reg + 32'h0000_0001;
    end
    if (!hold && wr_en != 4'h0) begin
      wr_cnt_next = wr_cnt_reg + 32'h0000_0001;
    end
    // a clear loses against nothing in flight; it is a software reset of the tally
    if (clr_cnt) begin
      rd_cnt_next = 32'h0000_0000;
      wr_cnt_next = 32'h0000_0000;
    end
  end

  // pipeline registers; reset parks the bus in high impedance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_kind_reg <= PSSC_NONE;
      s1_addr_reg <= 19'h0_0000;
      s1_bw_reg <= 4'hf;
      s2_kind_reg <= PSSC_NONE;
      s2_addr_reg <= 19'h0_0000;
      s2_bw_reg <= 4'hf;
      burst_kind_reg <= PSSC_NONE;
      burst_addr_reg <= 19'h0_0000;
      dq_out_reg <= 32'h0000_0000;
      dqp_out_reg <= 4'h0;
      dq_oe_reg <= 1'b0;
    end else begin
      s1_kind_reg <= s1_kind_next;
      s1_addr_reg <= s1_addr_next;
      s1_bw_reg <= s1_bw_next;
      s2_kind_reg <= s2_kind_next;
      s2_addr_reg <= s2_addr_next;
      s2_bw_reg <= s2_bw_next;
      burst_kind_reg <= burst_kind_next;
      burst_addr_reg <= burst_addr_next;
      dq_out_reg <= dq_out_next;
      dqp_out_reg <= dqp_out_next;
      dq_oe_reg <= dq_oe_next;
    end
  end

  // software-facing registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      narrow_reg <= `PSSC_CTRL_RESET;
      rd_cnt_reg <= 32'h0000_0000;
      wr_cnt_reg <= 32'h0000_0000;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      narrow_reg <= narrow_next;
      rd_cnt_reg <= rd_cnt_next;
      wr_cnt_reg <= wr_cnt_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // every output straight from a flop
  assign dq_out = dq_out_reg;
  assign dqp_out = dqp_out_reg;
  assign dq_oe = dq_oe_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule
`default_nettype wire

// file: pssc_defines.svh
`ifndef PSSC_DEFINES_SVH
`define PSSC_DEFINES_SVH

// array geometry: 512k words of four 9-bit lanes (8 data + 1 parity)
`define PSSC_ADDR_W 19
`define PSSC_DATA_W 32
`define PSSC_PAR_W 4
`define PSSC_LANES 4
`define PSSC_LANE_W 8
`define PSSC_WORD_W 36
`define PSSC_DEPTH 524288
`define PSSC_SEQ_W 2

// apb register map, byte addresses
`define PSSC_PADDR_W 12
`define PSSC_OFF_CTRL 12'h000
`define PSSC_OFF_STATUS 12'h004
`define PSSC_OFF_RDCNT 12'h008
`define PSSC_OFF_WRCNT 12'h00c

// control fields
`define PSSC_CTRL_NARROW 0
`define PSSC_CTRL_CLR 1
`define PSSC_CTRL_RESET 1'b0

// status fields
`define PSSC_ST_OE 0
`define PSSC_ST_KIND 1
`define PSSC_ST_SEQ 3
`define PSSC_ST_SCAN 5
`define PSSC_ST_SUSP 6

`endif

// file: pssc_pkg.sv
package pssc_pkg;

  // kind of access travelling down the pipeline, and the open burst's kind
  typedef enum logic [1:0] {PSSC_NONE, PSSC_READ, PSSC_WRITE} pssc_kind_t;

  // active-low byte-lane write strobes
  typedef logic [3:0] pssc_lanes_t;

endpackage

// file: pssc_burst_ctr.sv
`timescale 1ns/1ns
`default_nettype none
`include "pssc_defines.svh"

module pssc_burst_ctr (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control from the command decode
  input wire logic hold,
  input wire logic load,
  input wire logic advance,
  input wire logic interleaved,
  input wire logic [`PSSC_SEQ_W-1:0] start_lo,
  // address bits to use for this cycle's access, and the registered burst count
  output logic [`PSSC_SEQ_W-1:0] addr_lo,
  output logic [`PSSC_SEQ_W-1:0] count
);
  import pssc_pkg::*;

  logic [`PSSC_SEQ_W-1:0] base_reg;
  logic [`PSSC_SEQ_W-1:0] base_next;
  logic [`PSSC_SEQ_W-1:0] cnt_reg;
  logic [`PSSC_SEQ_W-1:0] cnt_next;

  // next counter state; a held edge changes nothing
  always_comb begin
    base_next = base_reg;
    cnt_next = cnt_reg;
    if (!hold) begin
      if (load) begin
        base_next = start_lo;
        cnt_next = 2'h0;
      end else if (advance) begin
        cnt_next = cnt_reg + 2'h1;
      end
    end
  end

  // the address follows the new count so an advance uses it in the same cycle
  always_comb begin
    if (interleaved) begin
      addr_lo = base_next ^ cnt_next;
    end else begin
      addr_lo = base_next + cnt_next;
    end
    count = cnt_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_reg <= 2'h0;
      cnt_reg <= 2'h0;
    end else begin
      base_reg <= base_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule
`default_nettype wire

// file: pssc_core_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "pssc_defines.svh"
module pssc_core_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [`PSSC_PADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // memory pins
  input wire logic clock_hold_n,
  input wire logic advance_or_load,
  input wire logic read_write,
  input wire logic select_low_a,
  input wire logic select_low_b,
  input wire logic select_high,
  input wire logic [`PSSC_DATA_W-1:0] dq_out,
  input wire logic dq_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // command classes at an edge that is not held
  wire logic chip_on = !select_low_a && !select_low_b && select_high;
  wire logic run = !clock_hold_n;
  wire logic ld = run && !advance_or_load;
  wire logic desel = ld && !chip_on;
  reset_float_a: assert property (!$past(presetn) |-> !dq_oe)
    else $error("data bus driven after reset");
  read_drive_a: assert property ((ld && chip_on && read_write) ##1 run [*2] |=> dq_oe)
    else $error("read data not driven");
  write_float_a: assert property ((ld && chip_on && !read_write) ##1 run [*2] |=> !dq_oe)
    else $error("bus driven in write data cycle");
  desel_float_a: assert property (desel ##1 run [*2] |=> !dq_oe)
    else $error("bus driven after deselect");
  noop_float_a: assert property (desel ##1 (run && advance_or_load) ##1 run [*2] |=> !dq_oe)
    else $error("bus driven after noop");
  hold_freeze_a: assert property (clock_hold_n |=> $stable(dq_oe) && $stable(dq_out))
    else $error("data pins moved on a held edge");
  apb_wait_a: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
    else $error("apb ready late");
  apb_err_a: assert property (pready && paddr > 12'h00c |-> pslverr)
    else $error("unmapped access not flagged");
  idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside ready");
  // main scenarios
  cover property ((ld && chip_on && read_write) ##1 (run && advance_or_load));
  cover property (clock_hold_n ##1 clock_hold_n);
  cover property (pready && pslverr);
endmodule
bind pssc_core pssc_core_props u_pssc_core_props (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready,
  .pslverr, .clock_hold_n, .advance_or_load, .read_write, .select_low_a, .select_low_b, .select_high, .dq_out, .dq_oe);
`default_nettype wire

// file: pssc_host.sv
`timescale 1ns/1ns
`default_nettype none
module pssc_host (
  // command pins
  output logic clock_hold_n,
  output logic advance_or_load,
  output logic read_write,
  output logic select_low_a,
  output logic select_low_b,
  output logic select_high,
  output logic [3:0] byte_lane_write_n,
  output logic burst_order_select,
  output logic [18:0] addr,
  // write data pins
  output logic [31:0] dq_in,
  output logic [3:0] dqp_in
);
  logic [36:0] p0 = '0;
  logic [36:0] p1 = '0;
  logic [36:0] last_d = '0;
  logic last_h = 1'b1;
  logic wk = 1'b0;
  // deselected while reset is held
  initial begin
    {burst_order_select, clock_hold_n, advance_or_load, read_write} = 4'h1;
    {select_low_a, select_low_b, select_high} = 3'b100;
    addr = 19'h0_0000;
    byte_lane_write_n = 4'hf;
    {dqp_in, dq_in} = 36'h0_0000_0000;
  end
  // one cycle; c packs order, hold, advance, direction and the three selects
  task automatic drive(input logic [6:0] c, input logic [18:0] a, input logic [3:0] bw, input logic [35:0] d);
    if (!last_h) begin
      p1 = p0;
      p0 = last_d;
    end
    {burst_order_select, clock_hold_n, advance_or_load, read_write} <= c[6:3];
    {select_low_a, select_low_b, select_high} <= c[2:0];
    addr <= a;
    byte_lane_write_n <= bw;
    // data trail two unheld edges; idle lines show the inverse so stale data never passes
    {dqp_in, dq_in} <= p1[36] ? p1[35:0] : ~{dqp_in, dq_in};
    if (!c[5] && !c[4]) wk = (c[2:0] == 3'b001) && !c[3];
    last_h = c[5];
    last_d = {wk, d};
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pssc_pkg::*;
  // {order, hold, advance, direction, select_low_a, select_low_b, select_high}
  localparam logic [6:0] LR = 7'h09;
  localparam logic [6:0] LW = 7'h01;
  localparam logic [6:0] AR = 7'h19;
  localparam logic [6:0] AW = 7'h11;
  localparam logic [6:0] HD = 7'h21;
  localparam logic [6:0] DS = 7'h08;
  localparam logic [3:0] BW [6] = '{4'he, 4'hd, 4'hb, 4'h7, 4'ha, 4'hf};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, dq_in, dq_out;
  logic pready, pslverr, clock_hold_n, advance_or_load, read_write, select_low_a, select_low_b, select_high;
  logic burst_order_select, dq_oe;
  pssc_lanes_t byte_lane_write_n;
  logic [18:0] addr;
  logic [3:0] dqp_in, dqp_out;
  int fails = 0;
  int checked = 0;
  logic [35:0] mem [int];
  logic [2:0][36:0] e = '0;
  logic [36:0] last_x = '0;
  logic last_h = 1'b1;
  logic narrow = 1'b0;
  logic [1:0] bk = 2'd0;
  logic [1:0] bn = 2'd0;
  logic [18:0] bs = 19'h0_0000;
  // 25 MHz
  always #20 pclk = ~pclk;
  pssc_core u_pssc_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .clock_hold_n, .advance_or_load, .read_write, .select_low_a, .select_low_b, .select_high, .byte_lane_write_n,
    .burst_order_select, .addr, .dq_in, .dqp_in, .dq_out, .dqp_out, .dq_oe);
  pssc_host u_pssc_host (.clock_hold_n, .advance_or_load, .read_write, .select_low_a, .select_low_b, .select_high,
    .byte_lane_write_n, .burst_order_select, .addr, .dq_in, .dqp_in);
  // comparisons
  task automatic chk_pin(input logic [36:0] got, input logic [36:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_apb(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [35:0] lm(input int i);
    return (36'h1_0000_0000 << i) | (36'h0_0000_00ff << (8 * i));
  endfunction
  // one command cycle; expectation pipe moves only on unheld edges
  task automatic op(input logic [6:0] c, input logic [18:0] a, input logic [3:0] bw, input logic [35:0] d);
    logic [18:0] aa;
    @(posedge pclk);
    u_pssc_host.drive(c, a, bw, d);
    #1;
    if (!last_h) e = {e[1:0], last_x};
    chk_pin({dq_oe, dq_oe ? {dqp_out, dq_out} : 36'h0}, e[2]);
    last_h = c[5];
    last_x = 37'h0;
    aa = a;
    if (!c[5]) begin
      if (!c[4]) begin
        bk = (c[2:0] != 3'b001) ? 2'd0 : c[3] ? 2'd1 : 2'd2;
        bs = a;
        bn = 2'd0;
      end else begin
        bn = bn + 2'd1;
        aa = {bs[18:2], c[6] ? bs[1:0] ^ bn : bs[1:0] + bn};
      end
      if (bk == 2'd2)
        for (int i = 0; i < 4; i++) if (!bw[i] && (i < 2 || !narrow)) mem[aa] = (mem[aa] & ~lm(i)) | (d & lm(i));
      if (bk == 2'd1) last_x = {1'b1, mem[aa] & (narrow ? 36'h3_0000_ffff : 36'hf_ffff_ffff)};
    end
  endtask
  // apb master: setup, access held until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] xd, input logic xe);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk_apb({31'h0, pslverr}, {31'h0, xe});
    if (!w) chk_apb(prdata, xd);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic final_report();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial begin
    logic [18:0] b;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
    // bursts in both orders, junk on the external address while advancing
    for (int k = 0; k < 2; k++) begin
      b = k ? 19'h0_0201 : 19'h0_0102;
      for (int i = 0; i < 4; i++) op((i ? AR : LW) | 7'(k << 6), b ^ 19'(i << 9), 4'h0, 36'h5_a5a5_0000 + 36'(i));
      for (int i = 0; i < 6; i++) op((i ? AW : LR) | 7'(k << 6), b ^ 19'(i << 9), 4'h0, 36'h0);
    end
    for (int i = 0; i < 6; i++) op(LW, 19'h0_0300 + 19'(i), 4'h0, 36'h0);
    for (int i = 0; i < 6; i++) op(LW, 19'h0_0300 + 19'(i), BW[i], {36{1'b1}});
    for (int i = 0; i < 6; i++) op(LR, 19'h0_0300 + 19'(i), 4'h0, 36'h0);
    for (int k = 0; k < 3; k++) begin
      op(LR, 19'h0_0300, 4'hf, 36'h0);
      op(k == 0 ? 7'h0d : k == 1 ? 7'h0b : DS, 19'h0, 4'hf, 36'h0);
      repeat (3) op(AR, 19'h0, 4'hf, 36'h0);
    end
    op(LR, 19'h0_0301, 4'hf, 36'h0);
    op(HD, 19'h0, 4'hf, 36'h0);
    op(AR, 19'h0, 4'hf, 36'h0);
    repeat (2) op(HD, 19'h0, 4'hf, 36'h0);
    // pins stay held during the bus read: open read burst, count one, suspend flag up, bus still floating
    apb(1'b0, 12'h004, 32'h0, 32'h0000_004a, 1'b0);
    op(AR, 19'h0, 4'hf, 36'h0);
    repeat (3) op(DS, 19'h0, 4'hf, 36'h0);
    apb(1'b1, 12'h000, 32'h1, 32'h0, 1'b0);
    narrow = 1'b1;
    op(LW, 19'h0_0400, 4'h0, {36{1'b1}});
    op(DS, 19'h0, 4'hf, 36'h0);
    op(LR, 19'h0_0400, 4'h0, 36'h0);
    repeat (3) op(DS, 19'h0, 4'hf, 36'h0);
    // tallies: 25 data-stage reads, 20 writes (the all-strobes-high write and advances after a stop do not count)
    apb(1'b0, 12'h008, 32'h0, 32'h0000_0019, 1'b0);
    apb(1'b0, 12'h00c, 32'h0, 32'h0000_0014, 1'b0);
    // clear the tallies; pins are deselected so nothing can count in between
    apb(1'b1, 12'h000, 32'h3, 32'h0, 1'b0);
    apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h000, 32'h0, 32'h1, 1'b0);
    final_report();
  end
  // watchdog against a hung handshake
  initial begin
    #200000;
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
